/* rtl/lrs_pkg.sv */
package lrs_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned LVL_W = 3;
  localparam int unsigned WREG_W = 4;
  localparam int unsigned STALL_CYCLES = 1;
  // Register map, byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_START = 12'h004;
  localparam logic [11:0] REG_END = 12'h008;
  localparam logic [11:0] REG_COUNT = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_STATS = 12'h014;
  // Field positions
  localparam int unsigned CTRL_EXIT_BIT = 0;
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_LVL_LSB = 8;
  localparam int unsigned STAT_STALL_BIT = 4;
  localparam logic [LVL_W-1:0] LVL_NONE = 3'h0;
  localparam logic [LVL_W-1:0] LVL_ONE = 3'h1;
  localparam logic [LVL_W-1:0] LVL_TWO = 3'h2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h000002;
  typedef enum logic [1:0] {
    LRS_RUN = 2'b00,
    LRS_STALL = 2'b01,
    LRS_IRQ = 2'b10
  } lrs_state_type;
endpackage : lrs_pkg

/* rtl/lrs_seq.sv */
module lrs_seq
  import lrs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction pipeline, same clock
  input wire logic loop_instr_exec,
  input wire logic [ADDR_W-1:0] loop_start_in,
  input wire logic [ADDR_W-1:0] loop_end_in,
  input wire logic [CNT_W-1:0] loop_count_in,
  input wire logic [ADDR_W-1:0] prefetch_addr,
  input wire logic cur_writes_wreg,
  input wire logic [WREG_W-1:0] cur_dest_wreg,
  input wire logic pf_uses_ea,
  input wire logic [WREG_W-1:0] pf_ea_wreg,
  input wire logic irq_request,
  // Sequencer outputs
  output logic redirect_valid,
  output logic [ADDR_W-1:0] redirect_addr,
  output logic stall,
  output logic irq_take,
  output logic loop_active_flag,
  output logic [LVL_W-1:0] loop_nesting_level
);

  logic [ADDR_W-1:0] start_q, end_q, start_sh_q, end_sh_q;
  logic [CNT_W-1:0] count_q, count_sh_q;
  logic [LVL_W-1:0] lvl_q;
  logic exit_req_q;
  logic [15:0] stall_cnt_q;
  lrs_state_type state_q;
  logic irq_hold_q;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction : hit

  wire apb_wr = psel && penable && pwrite;
  wire sw_exit = apb_wr && hit(paddr, REG_CTRL) && pwdata[CTRL_EXIT_BIT];
  wire active = |lvl_q;
  // Compare runs whatever the flow, so a return as last word still ends right
  wire end_seen = active && (prefetch_addr == end_q);
  wire exit_any = exit_req_q || sw_exit;
  // Count zero means this pass is the last; early exit also finishes here
  wire last_pass = (count_q == CNT_ZERO) || exit_any;
  wire loop_done = end_seen && last_pass;
  // Hazard between write destination and prefetched address source
  wire raw_hit = cur_writes_wreg && pf_uses_ea && (cur_dest_wreg == pf_ea_wreg);

  // Loop registers and nesting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= '0;
      end_q <= '0;
      count_q <= CNT_ZERO;
      start_sh_q <= '0;
      end_sh_q <= '0;
      count_sh_q <= CNT_ZERO;
      lvl_q <= LVL_NONE;
    end else if (loop_instr_exec) begin
      start_sh_q <= start_q;
      end_sh_q <= end_q;
      count_sh_q <= count_q;
      start_q <= loop_start_in;
      end_q <= loop_end_in;
      count_q <= loop_count_in;
      if (lvl_q != 3'h7) begin
        lvl_q <= lvl_q + LVL_ONE;
      end
    end else if (apb_wr && hit(paddr, REG_START)) begin
      start_q <= pwdata[ADDR_W-1:0];
    end else if (apb_wr && hit(paddr, REG_END)) begin
      end_q <= pwdata[ADDR_W-1:0];
    end else if (apb_wr && hit(paddr, REG_COUNT)) begin
      count_q <= pwdata[CNT_W-1:0];
    end else if (loop_done) begin
      // Same unwind for early exit and exhaustion
      lvl_q <= lvl_q - LVL_ONE;
      if (lvl_q == LVL_TWO) begin
        start_q <= start_sh_q;
        end_q <= end_sh_q;
        count_q <= count_sh_q;
      end
    end else if (end_seen) begin
      count_q <= count_q - CNT_ONE;
    end
  end

  // Exit request held until the end address comes round or a loop instruction executes; a request in
  // the same cycle as the end address also ends this pass, no extra one runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_req_q <= 1'b0;
    end else if (loop_done || loop_instr_exec) begin
      exit_req_q <= 1'b0;
    end else if (sw_exit && active) begin
      exit_req_q <= 1'b1;
    end
  end

  // Fetch redirect to start while looping; length zero reloads same word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      redirect_valid <= 1'b0;
      redirect_addr <= '0;
    end else begin
      redirect_valid <= end_seen && !last_pass;
      redirect_addr <= loop_done ? prefetch_addr + ADDR_STEP : start_q;
    end
  end

  // Stall and interrupt sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LRS_RUN;
      stall <= 1'b0;
      irq_take <= 1'b0;
      irq_hold_q <= 1'b0;
    end else begin
      irq_take <= 1'b0;
      stall <= 1'b0;
      case (state_q)
        LRS_RUN: begin
          if (irq_request && !raw_hit) begin
            // No write hazard pending, so the interrupt is taken at once with no stall
            irq_take <= 1'b1;
          end else if (raw_hit) begin
            stall <= 1'b1;
            irq_hold_q <= irq_request;
            state_q <= LRS_STALL;
          end
        end
        LRS_STALL: begin
          if (irq_hold_q || irq_request) begin
            state_q <= LRS_IRQ;
          end else begin
            state_q <= LRS_RUN;
          end
          irq_hold_q <= 1'b0;
        end
        LRS_IRQ: begin
          irq_take <= 1'b1;
          state_q <= LRS_RUN;
        end
        default: state_q <= LRS_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt_q <= 16'h0000;
    end else if (raw_hit && state_q == LRS_RUN) begin
      stall_cnt_q <= stall_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_active_flag <= 1'b0;
      loop_nesting_level <= LVL_NONE;
    end else begin
      loop_active_flag <= |lvl_q;
      loop_nesting_level <= lvl_q;
    end
  end

  // APB: zero wait, unmapped reads zero with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          REG_CTRL: prdata <= 32'h0000_0000;
          REG_START: prdata <= {8'h00, start_q};
          REG_END: prdata <= {8'h00, end_q};
          REG_COUNT: prdata <= {16'h0000, count_q};
          REG_STATUS: prdata <= {21'h0, lvl_q, 3'h0, stall, 3'h0, active};
          REG_STATS: prdata <= {16'h0000, stall_cnt_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  property p_active_or;
    @(posedge pclk) disable iff (!presetn) loop_active_flag == |$past(lvl_q);
  endproperty
  a_active_or: assert property (p_active_or) else $error("active flag mismatch");

  property p_stall_on_hit;
    @(posedge pclk) disable iff (!presetn)
      (raw_hit && state_q == LRS_RUN && !irq_request) |=> stall ##1 !stall;
  endproperty
  a_stall_on_hit: assert property (p_stall_on_hit) else $error("missing one stall");

  property p_no_false_stall;
    @(posedge pclk) disable iff (!presetn) stall |-> $past(raw_hit);
  endproperty
  a_no_false_stall: assert property (p_no_false_stall) else $error("spurious stall");

  property p_irq_after_stall;
    @(posedge pclk) disable iff (!presetn)
      (raw_hit && state_q == LRS_RUN && irq_request) |=> stall ##2 irq_take;
  endproperty
  a_irq_after_stall: assert property (p_irq_after_stall) else $error("irq not after stall");

  property p_irq_first;
    @(posedge pclk) disable iff (!presetn)
      (state_q == LRS_RUN && irq_request && !raw_hit) |=> irq_take && !stall;
  endproperty
  a_irq_first: assert property (p_irq_first) else $error("irq on first wrong");

  property p_done_unwind;
    @(posedge pclk) disable iff (!presetn)
      (loop_done && !loop_instr_exec && !apb_wr) |=> lvl_q == $past(lvl_q) - LVL_ONE;
  endproperty
  a_done_unwind: assert property (p_done_unwind) else $error("level not unwound");

  property p_exit_read_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == REG_CTRL) |=> prdata == 32'h0;
  endproperty
  a_exit_read_zero: assert property (p_exit_read_zero) else $error("exit bit read nonzero");

  property p_no_redirect_idle;
    @(posedge pclk) disable iff (!presetn) !active |=> !redirect_valid;
  endproperty
  a_no_redirect_idle: assert property (p_no_redirect_idle) else $error("redirect while idle");

  property p_decrement;
    @(posedge pclk) disable iff (!presetn)
      (end_seen && !last_pass && !loop_instr_exec && !apb_wr) |=> count_q == $past(count_q) - CNT_ONE;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count not decremented");

  c_stall: cover property (@(posedge pclk) disable iff (!presetn) stall);
  c_loop_done: cover property (@(posedge pclk) disable iff (!presetn) loop_done);
  c_early_exit: cover property (@(posedge pclk) disable iff (!presetn) loop_done && exit_req_q);
  c_irq_stall: cover property (@(posedge pclk) disable iff (!presetn) state_q == LRS_IRQ);

endmodule : lrs_seq

/* tb/testbench.sv */
module testbench
  import lrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ard;
  logic aerr, loop_instr_exec, cur_writes_wreg, pf_uses_ea, irq_request;
  logic [ADDR_W-1:0] loop_start_in, loop_end_in, prefetch_addr, redirect_addr;
  logic [CNT_W-1:0] loop_count_in;
  logic [WREG_W-1:0] cur_dest_wreg, pf_ea_wreg;
  logic redirect_valid, stall, irq_take, loop_active_flag;
  logic [LVL_W-1:0] loop_nesting_level;
  int miscompares, checks_done, cyc_n, m_lvl, m_exit;
  logic [31:0] m_st, m_en, m_ct, s_st, s_en, s_ct;
  localparam logic [ADDR_W-1:0] IDLE_PF = 24'h000ffe;

  lrs_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .loop_instr_exec(loop_instr_exec), .loop_start_in(loop_start_in),
    .loop_end_in(loop_end_in), .loop_count_in(loop_count_in), .prefetch_addr(prefetch_addr),
    .cur_writes_wreg(cur_writes_wreg), .cur_dest_wreg(cur_dest_wreg), .pf_uses_ea(pf_uses_ea),
    .pf_ea_wreg(pf_ea_wreg), .irq_request(irq_request), .redirect_valid(redirect_valid),
    .redirect_addr(redirect_addr), .stall(stall), .irq_take(irq_take),
    .loop_active_flag(loop_active_flag), .loop_nesting_level(loop_nesting_level));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // Setup edge, then hold the access phase until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    ard = prdata;
    aerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a == REG_CTRL && d[CTRL_EXIT_BIT]) m_exit = 1;
  endtask : apb

  task automatic idle_all();
    loop_instr_exec <= 1'b0;
    prefetch_addr <= IDLE_PF;
    cur_writes_wreg <= 1'b0;
    pf_uses_ea <= 1'b0;
    irq_request <= 1'b0;
  endtask : idle_all

  task automatic do_loop(input logic [23:0] st, input logic [23:0] en, input logic [15:0] ct);
    @(posedge pclk);
    loop_instr_exec <= 1'b1;
    loop_start_in <= st;
    loop_end_in <= en;
    loop_count_in <= ct;
    @(posedge pclk);
    idle_all();
    s_st = m_st;
    s_en = m_en;
    s_ct = m_ct;
    m_st = st;
    m_en = en;
    m_ct = ct;
    m_lvl++;
  endtask : do_loop

  task automatic op(input logic [23:0] pf, input logic wr, input logic [3:0] dw,
                    input logic ue, input logic [3:0] ew, input logic irq);
    logic e_rd, e_st, got;
    e_rd = 1'b0;
    got = 1'b0;
    e_st = wr && ue && (dw == ew);
    if (pf == m_en[23:0] && m_lvl > 0) begin
      if (m_ct != 0 && m_exit == 0) begin
        e_rd = 1'b1;
        m_ct--;
      end else begin
        m_lvl--;
        m_exit = 0;
        if (m_lvl == 1) begin
          m_st = s_st;
          m_en = s_en;
          m_ct = s_ct;
        end
      end
    end
    @(posedge pclk);
    prefetch_addr <= pf;
    cur_writes_wreg <= wr;
    cur_dest_wreg <= dw;
    pf_uses_ea <= ue;
    pf_ea_wreg <= ew;
    irq_request <= irq;
    @(posedge pclk);
    idle_all();
    #1;
    chk("redirect_valid", e_rd, redirect_valid);
    if (e_rd) chk("redirect_addr", m_st, redirect_addr);
    chk("stall", e_st, stall);
    chk("irq_take", irq && !e_st, irq_take);
    if (e_st) begin
      @(posedge pclk);
      #1;
      chk("stall end", 0, stall);
      got = irq_take;
      repeat (2) begin
        @(posedge pclk);
        #1;
        got = got | irq_take;
      end
      chk("irq after stall", irq, got);
    end
  endtask : op

  task automatic lvl_check();
    repeat (2) @(posedge pclk);
    #1;
    chk("level", m_lvl, loop_nesting_level);
    chk("active", m_lvl != 0, loop_active_flag);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", {m_lvl[2:0], 7'h00, m_lvl != 0}, {ard[10:8], ard[7:1] & 7'h00, ard[0]});
  endtask : lvl_check

  initial begin
    int i;
    logic [3:0] a, b;
    {psel, penable, pwrite, paddr, pwdata, loop_instr_exec, cur_writes_wreg} = '0;
    {pf_uses_ea, irq_request, loop_start_in, loop_end_in, loop_count_in} = '0;
    {cur_dest_wreg, pf_ea_wreg} = '0;
    prefetch_addr = IDLE_PF;
    {miscompares, checks_done, cyc_n, m_lvl, m_exit} = '0;
    {m_st, m_en, m_ct, s_st, s_en, s_ct} = '0;
    void'($urandom(32'h17a6));
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl read", 0, ard);
    m_exit = 0;
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 1, aerr);
    chk("unmapped data", 0, ard);
    $display("registers done");
    do_loop(24'h000100, 24'h000108, 16'h0002);
    lvl_check();
    apb(1'b1, REG_CTRL, 32'h0);
    op(24'h000104, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    for (i = 0; i < 3; i++) op(24'h000108, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    lvl_check();
    $display("counted loop done");
    do_loop(24'h000200, 24'h00020a, 16'h0005);
    apb(1'b1, REG_CTRL, 32'h1);
    op(24'h00020a, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    lvl_check();
    $display("early exit done");
    do_loop(24'h000300, 24'h000310, 16'h0001);
    do_loop(24'h000304, 24'h000308, 16'h0000);
    lvl_check();
    op(24'h000308, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    lvl_check();
    apb(1'b0, REG_END, 32'h0);
    chk("restored end", m_en, ard);
    apb(1'b1, REG_CTRL, 32'h1);
    op(24'h000310, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    lvl_check();
    $display("nested loop done");
    do_loop(24'h000400, 24'h000404, 16'h0003);
    op(24'h000404, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    apb(1'b1, REG_CTRL, 32'h1);
    op(24'h000404, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    lvl_check();
    do_loop(24'h000500, 24'h000500, 16'h0001);
    op(24'h000500, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    op(24'h000500, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    lvl_check();
    $display("late exit and short loop done");
    for (i = 0; i < 24; i++) begin
      a = 4'($urandom_range(15));
      b = ($urandom_range(1) != 0) ? a : 4'($urandom_range(15));
      op(IDLE_PF, 1'($urandom_range(1)), a, 1'($urandom_range(1)), b, i[2] & i[0]);
    end
    op(IDLE_PF, 1'b1, 4'h5, 1'b1, 4'h5, 1'b1);
    op(IDLE_PF, 1'b1, 4'h5, 1'b1, 4'h6, 1'b1);
    $display("stall tests done");
    complete_run();
  end
endmodule : testbench
